// [verilog/ntme_pkg.sv]
// Shared constants and carriers for the trace message encoder.
// Assumes a single core clock domain and a request source that holds its request until taken.
package ntme_pkg;

	// ------------------------------------------------------------------
	// Port and packet widths
	// ------------------------------------------------------------------
	localparam int unsigned PORT_W   = 4;
	localparam int unsigned MAX_PKTS = 4;
	localparam logic [5:0]  LEN_TCODE = 6'h06;
	localparam logic [5:0]  LEN_ICNT  = 6'h08;
	localparam logic [5:0]  LEN_ADDR  = 6'h20;
	localparam logic [5:0]  LEN_DATA  = 6'h20;
	localparam logic [5:0]  LEN_RDATA = 6'h08;
	localparam logic [5:0]  LEN_CODE4 = 6'h04;
	localparam logic [5:0]  LEN_TWO   = 6'h02;
	localparam logic [5:0]  LEN_BITNO = 6'h05;
	localparam logic [1:0]  FILL_LAST = 2'h3;

	// ------------------------------------------------------------------
	// Transfer codes
	// ------------------------------------------------------------------
	localparam logic [5:0] TC_DIRECT      = 6'h03;
	localparam logic [5:0] TC_INDIRECT    = 6'h04;
	localparam logic [5:0] TC_WRITE       = 6'h05;
	localparam logic [5:0] TC_READ        = 6'h06;
	localparam logic [5:0] TC_SYNC        = 6'h09;
	localparam logic [5:0] TC_DIRECT_S    = 6'h0b;
	localparam logic [5:0] TC_INDIRECT_S  = 6'h0c;
	localparam logic [5:0] TC_WRITE_S     = 6'h0d;
	localparam logic [5:0] TC_READ_S      = 6'h0e;
	localparam logic [5:0] TC_RES_FULL    = 6'h1b;
	localparam logic [5:0] TC_CORREL      = 6'h21;
	localparam logic [5:0] TC_WATCH       = 6'h38;
	localparam logic [5:0] TC_DIRECT_TGT  = 6'h39;
	localparam logic [5:0] TC_RMW         = 6'h3a;
	localparam logic [5:0] TC_RMW_S       = 6'h3b;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [3:0] RST_BEAT = 4'h0;

	typedef enum logic [3:0] {
		NTME_K_DIRECT,
		NTME_K_DIRECT_TGT,
		NTME_K_INDIRECT,
		NTME_K_SYNC,
		NTME_K_RES_FULL,
		NTME_K_CORREL,
		NTME_K_WRITE,
		NTME_K_READ,
		NTME_K_RMW,
		NTME_K_WATCH
	} ntme_kind_t;

	typedef struct packed {
		ntme_kind_t  kind;
		logic        sync_needed;
		logic [7:0]  instruction_count;
		logic [1:0]  event_identifier;
		logic [3:0]  code4;
		logic [1:0]  two_bit_field;
		logic [4:0]  bit_number;
		logic [7:0]  resource_data;
		logic [31:0] address;
		logic [31:0] data;
	} ntme_req_t;

	typedef struct packed {
		logic        valid;
		logic [3:0]  data;
		logic        pkt_end;
		logic        msg_end;
	} ntme_beat_t;

endpackage

// [verilog/ntme_encoder.sv]
// Trace message encoder: turns one trace request into a stream of 4-bit port beats.
// Assumes the request source holds I_REQ stable while I_REQ_VALID is high and not yet taken.
`timescale 1ns/10ps

// Behaviour
// - Each message starts with a six-bit transfer code, then its packets in order.
// - Direct branch sends code 3 with the instruction count.
// - Direct branch with target sends code 57, count, then unique target address.
// - Indirect branch sends code 4 with event identifier, count, unique address.
// - Synchronization sends code 9 with count and full program counter.
// - Direct branch with sync sends code 11 with count and full target.
// - Indirect branch with sync sends code 12 with identifier, count, full target.
// - Resource overflow sends code 27 with resource code and resource data.
// - Correlation sends code 33 with event code and instruction count.
// - Data write sends code 5 with size, unique address, written data.
// - Data read sends code 6 with size, unique address, read data.
// - Data write with sync sends code 13 with size, full address, data.
// - Data read with sync sends code 14 with size, full address, data.
// - Read-modify-write sends code 58 with type, bit number, unique address.
// - Read-modify-write with sync sends code 59 with type, bit number, full address.
// - Trace watchpoint sends code 56 with the two-bit hit mask.
// - Reserved transfer codes are never emitted.
// - Variable packets drop leading zero bits, keeping at least one bit.
// - Variable packets are zero padded to end on a port beat boundary.
// - Fixed packets are always sent at full width.
module ntme_encoder (
	// Clock and reset
	input  wire logic              I_CLK,
	input  wire logic              I_SYS_RST,
	// Trace request from the core
	input  wire logic              I_REQ_VALID,
	input  wire ntme_pkg::ntme_req_t I_REQ,
	output logic                   O_REQ_READY,
	// Auxiliary trace port
	output ntme_pkg::ntme_beat_t   O_AUX
);

	// ------------------------------------------------------------------
	// State and storage
	// ------------------------------------------------------------------
	typedef enum logic {
		NTME_ST_IDLE,
		NTME_ST_SEND
	} ntme_state_t;

	ntme_state_t          state_reg;
	ntme_state_t          state_next;
	logic [31:0]          pkt_data_reg [ntme_pkg::MAX_PKTS];
	logic [5:0]           pkt_len_reg  [ntme_pkg::MAX_PKTS];
	logic                 pkt_var_reg  [ntme_pkg::MAX_PKTS];
	logic [1:0]           pkt_last_reg;
	logic [1:0]           pkt_idx_reg;
	logic [5:0]           bit_idx_reg;
	logic [3:0]           acc_reg;
	logic [1:0]           fill_reg;
	logic                 ready_reg;
	ntme_pkg::ntme_beat_t beat_reg;

	logic [31:0]          ld_data [ntme_pkg::MAX_PKTS];
	logic [5:0]           ld_len  [ntme_pkg::MAX_PKTS];
	logic                 ld_var  [ntme_pkg::MAX_PKTS];
	logic [1:0]           ld_last;
	logic [5:0]           ld_tcode;
	logic                 accept;
	logic                 cur_bit;
	logic [3:0]           acc_next;
	logic                 pkt_done;
	logic                 last_pkt;
	logic                 flush;
	logic                 emit;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Number of significant bits of a value, never less than one.
	function automatic logic [5:0] sig_len(input logic [31:0] value, input logic [5:0] width);
		logic [5:0] len;
		len = 6'h01;
		for (int i = 0; i < 32; i++) begin
			if (value[i] && (i < int'(width))) begin
				len = 6'(i + 1);
			end
		end
		return len;
	endfunction

	// True for transfer codes that the port must never carry.
	function automatic logic tcode_reserved(input logic [5:0] code);
		logic hit;
		hit = 1'b0;
		if ((code == 6'h01) || (code == 6'h07) || (code == 6'h0a)) begin
			hit = 1'b1;
		end else if ((code >= 6'h10) && (code <= 6'h1a)) begin
			hit = 1'b1;
		end else if ((code >= 6'h1c) && (code <= 6'h20)) begin
			hit = 1'b1;
		end else if ((code >= 6'h22) && (code <= 6'h37)) begin
			hit = 1'b1;
		end else if ((code >= 6'h3c) && (code <= 6'h3e)) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	assign accept = I_REQ_VALID && ready_reg;

	// ------------------------------------------------------------------
	// Message assembly from the request
	// ------------------------------------------------------------------
	always_comb begin
		ld_tcode = ntme_pkg::TC_DIRECT;
		ld_last  = 2'h1;
		for (int p = 0; p < int'(ntme_pkg::MAX_PKTS); p++) begin
			ld_data[p] = 32'h0000_0000;
			ld_len[p]  = ntme_pkg::LEN_TWO;
			ld_var[p]  = 1'b0;
		end
		case (I_REQ.kind)
			ntme_pkg::NTME_K_DIRECT: begin
				ld_tcode = I_REQ.sync_needed ? ntme_pkg::TC_DIRECT_S
				                             : ntme_pkg::TC_DIRECT;
				ld_data[1] = {24'h00_0000, I_REQ.instruction_count};
				ld_len[1]  = ntme_pkg::LEN_ICNT;
				ld_var[1]  = 1'b1;
				if (I_REQ.sync_needed) begin
					ld_data[2] = I_REQ.address;
					ld_len[2]  = ntme_pkg::LEN_ADDR;
					ld_var[2]  = 1'b1;
					ld_last    = 2'h2;
				end
			end
			ntme_pkg::NTME_K_DIRECT_TGT: begin
				ld_tcode   = ntme_pkg::TC_DIRECT_TGT;
				ld_data[1] = {24'h00_0000, I_REQ.instruction_count};
				ld_len[1]  = ntme_pkg::LEN_ICNT;
				ld_var[1]  = 1'b1;
				ld_data[2] = I_REQ.address;
				ld_len[2]  = ntme_pkg::LEN_ADDR;
				ld_var[2]  = 1'b1;
				ld_last    = 2'h2;
			end
			ntme_pkg::NTME_K_INDIRECT: begin
				ld_tcode = I_REQ.sync_needed ? ntme_pkg::TC_INDIRECT_S
				                             : ntme_pkg::TC_INDIRECT;
				ld_data[1] = {30'h0000_0000, I_REQ.event_identifier};
				ld_data[2] = {24'h00_0000, I_REQ.instruction_count};
				ld_len[2]  = ntme_pkg::LEN_ICNT;
				ld_var[2]  = 1'b1;
				ld_data[3] = I_REQ.address;
				ld_len[3]  = ntme_pkg::LEN_ADDR;
				ld_var[3]  = 1'b1;
				ld_last    = 2'h3;
			end
			ntme_pkg::NTME_K_SYNC: begin
				ld_tcode   = ntme_pkg::TC_SYNC;
				ld_data[1] = {24'h00_0000, I_REQ.instruction_count};
				ld_len[1]  = ntme_pkg::LEN_ICNT;
				ld_var[1]  = 1'b1;
				ld_data[2] = I_REQ.address;
				ld_len[2]  = ntme_pkg::LEN_ADDR;
				ld_var[2]  = 1'b1;
				ld_last    = 2'h2;
			end
			ntme_pkg::NTME_K_RES_FULL: begin
				ld_tcode   = ntme_pkg::TC_RES_FULL;
				ld_data[1] = {28'h000_0000, I_REQ.code4};
				ld_len[1]  = ntme_pkg::LEN_CODE4;
				ld_data[2] = {24'h00_0000, I_REQ.resource_data};
				ld_len[2]  = ntme_pkg::LEN_RDATA;
				ld_var[2]  = 1'b1;
				ld_last    = 2'h2;
			end
			ntme_pkg::NTME_K_CORREL: begin
				ld_tcode   = ntme_pkg::TC_CORREL;
				ld_data[1] = {28'h000_0000, I_REQ.code4};
				ld_len[1]  = ntme_pkg::LEN_CODE4;
				ld_data[2] = {24'h00_0000, I_REQ.instruction_count};
				ld_len[2]  = ntme_pkg::LEN_ICNT;
				ld_var[2]  = 1'b1;
				ld_last    = 2'h2;
			end
			ntme_pkg::NTME_K_WRITE,
			ntme_pkg::NTME_K_READ: begin
				if (I_REQ.kind == ntme_pkg::NTME_K_WRITE) begin
					ld_tcode = I_REQ.sync_needed ? ntme_pkg::TC_WRITE_S
					                             : ntme_pkg::TC_WRITE;
				end else begin
					ld_tcode = I_REQ.sync_needed ? ntme_pkg::TC_READ_S
					                             : ntme_pkg::TC_READ;
				end
				ld_data[1] = {30'h0000_0000, I_REQ.two_bit_field};
				ld_data[2] = I_REQ.address;
				ld_len[2]  = ntme_pkg::LEN_ADDR;
				ld_var[2]  = 1'b1;
				ld_data[3] = I_REQ.data;
				ld_len[3]  = ntme_pkg::LEN_DATA;
				ld_var[3]  = 1'b1;
				ld_last    = 2'h3;
			end
			ntme_pkg::NTME_K_RMW: begin
				ld_tcode = I_REQ.sync_needed ? ntme_pkg::TC_RMW_S
				                             : ntme_pkg::TC_RMW;
				ld_data[1] = {30'h0000_0000, I_REQ.two_bit_field};
				ld_data[2] = {27'h000_0000, I_REQ.bit_number};
				ld_len[2]  = ntme_pkg::LEN_BITNO;
				ld_data[3] = I_REQ.address;
				ld_len[3]  = ntme_pkg::LEN_ADDR;
				ld_var[3]  = 1'b1;
				ld_last    = 2'h3;
			end
			ntme_pkg::NTME_K_WATCH: begin
				ld_tcode   = ntme_pkg::TC_WATCH;
				ld_data[1] = {30'h0000_0000, I_REQ.two_bit_field};
			end
			default: begin
				// Unknown kinds fall back to a plain direct branch, so no reserved code escapes.
				ld_tcode   = ntme_pkg::TC_DIRECT;
				ld_data[1] = {24'h00_0000, I_REQ.instruction_count};
				ld_len[1]  = ntme_pkg::LEN_ICNT;
				ld_var[1]  = 1'b1;
			end
		endcase
		// A reserved code is never let onto the port; it is replaced by the direct branch code.
		if (tcode_reserved(ld_tcode)) begin
			ld_tcode = ntme_pkg::TC_DIRECT;
		end
		ld_data[0] = {26'h000_0000, ld_tcode};
		ld_len[0]  = ntme_pkg::LEN_TCODE;
		// Variable packets keep only their significant bits; fixed ones keep full width.
		for (int p = 1; p < int'(ntme_pkg::MAX_PKTS); p++) begin
			if (ld_var[p]) begin
				ld_len[p] = sig_len(ld_data[p], ld_len[p]);
			end
		end
	end

	// ------------------------------------------------------------------
	// Bit serialiser
	// ------------------------------------------------------------------
	always_comb begin
		cur_bit  = pkt_data_reg[pkt_idx_reg][bit_idx_reg[4:0]];
		acc_next = acc_reg | (4'(cur_bit) << fill_reg);
		pkt_done = (bit_idx_reg == (pkt_len_reg[pkt_idx_reg] - 6'h01));
		last_pkt = (pkt_idx_reg == pkt_last_reg);
		flush    = pkt_done && (pkt_var_reg[pkt_idx_reg] || last_pkt);
		emit     = (fill_reg == ntme_pkg::FILL_LAST) || flush;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			NTME_ST_IDLE: begin
				if (accept) begin
					state_next = NTME_ST_SEND;
				end
			end
			NTME_ST_SEND: begin
				if (pkt_done && last_pkt) begin
					state_next = NTME_ST_IDLE;
				end
			end
			default: begin
				state_next = NTME_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			state_reg <= NTME_ST_IDLE;
			ready_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ready_reg <= (state_next == NTME_ST_IDLE);
		end
	end

	// Packet store is loaded once per message and read by the serialiser.
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			pkt_last_reg <= 2'h0;
			for (int p = 0; p < int'(ntme_pkg::MAX_PKTS); p++) begin
				pkt_data_reg[p] <= 32'h0000_0000;
				pkt_len_reg[p]  <= ntme_pkg::LEN_TWO;
				pkt_var_reg[p]  <= 1'b0;
			end
		end else if (accept) begin
			pkt_last_reg <= ld_last;
			for (int p = 0; p < int'(ntme_pkg::MAX_PKTS); p++) begin
				pkt_data_reg[p] <= ld_data[p];
				pkt_len_reg[p]  <= ld_len[p];
				pkt_var_reg[p]  <= ld_var[p];
			end
		end
	end

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			pkt_idx_reg <= 2'h0;
			bit_idx_reg <= 6'h00;
		end else if (accept) begin
			pkt_idx_reg <= 2'h0;
			bit_idx_reg <= 6'h00;
		end else if (state_reg == NTME_ST_SEND) begin
			if (pkt_done) begin
				pkt_idx_reg <= pkt_idx_reg + 2'h1;
				bit_idx_reg <= 6'h00;
			end else begin
				bit_idx_reg <= bit_idx_reg + 6'h01;
			end
		end
	end

	// Fixed packets run straight into the next packet inside a beat; padding only on flush.
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			acc_reg  <= ntme_pkg::RST_BEAT;
			fill_reg <= 2'h0;
		end else if (accept) begin
			acc_reg  <= ntme_pkg::RST_BEAT;
			fill_reg <= 2'h0;
		end else if (state_reg == NTME_ST_SEND) begin
			if (emit) begin
				acc_reg  <= ntme_pkg::RST_BEAT;
				fill_reg <= 2'h0;
			end else begin
				acc_reg  <= acc_next;
				fill_reg <= fill_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			beat_reg <= '0;
		end else if ((state_reg == NTME_ST_SEND) && emit) begin
			beat_reg.valid   <= 1'b1;
			beat_reg.data    <= acc_next;
			beat_reg.pkt_end <= flush;
			beat_reg.msg_end <= pkt_done && last_pkt;
		end else begin
			beat_reg <= '0;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign O_REQ_READY = ready_reg;
	assign O_AUX       = beat_reg;

endmodule

// [verification/ntme_probe.sv]
// Trace probe model: captures every port beat and counts complete messages.
// Assumes the beat format of the package; the probe never stalls the port.
`timescale 1ns/10ps
module ntme_probe (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	// Auxiliary port
	input  wire ntme_pkg::ntme_beat_t i_aux,
	// Captured beats and message count
	output logic                      o_strobe,
	output ntme_pkg::ntme_beat_t      o_beat,
	output logic [15:0]               o_msgs
);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_strobe <= 1'b0;
			o_beat   <= '0;
		end else begin
			o_strobe <= i_aux.valid;
			o_beat   <= i_aux;
		end
	end
	// A message is counted only when its last beat also closes a packet.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_msgs <= 16'h0000;
		else if (i_aux.valid && i_aux.msg_end && i_aux.pkt_end)
			o_msgs <= o_msgs + 16'h0001;
	end
endmodule

// [verification/ntme_encoder_asserts.sv]
// Checker for the trace message encoder, watching only its top-level ports.
// Assumes one clock domain; bound to the encoder at the foot of this file.
`timescale 1ns/10ps
module ntme_encoder_asserts (
	input wire logic                 I_CLK,
	input wire logic                 I_SYS_RST,
	input wire logic                 I_REQ_VALID,
	input wire ntme_pkg::ntme_req_t  I_REQ,
	input wire logic                 O_REQ_READY,
	input wire ntme_pkg::ntme_beat_t O_AUX
);
	logic                 take_w;
	logic [7:0]           nbeat_reg;
	logic [3:0]           lo_reg;
	ntme_pkg::ntme_kind_t kind_reg;

	assign take_w = I_REQ_VALID && O_REQ_READY;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST)
			nbeat_reg <= 8'h00;
		else if (O_AUX.valid)
			nbeat_reg <= O_AUX.msg_end ? 8'h00 : nbeat_reg + 8'h01;
	end
	always_ff @(posedge I_CLK) begin
		if (O_AUX.valid)
			lo_reg <= O_AUX.data;
	end
	always_ff @(posedge I_CLK) begin
		if (take_w)
			kind_reg <= I_REQ.kind;
	end

	a_ready_drop: assert property (take_w |=> !O_REQ_READY)
		else $error("ready stayed high after a request was taken");
	a_first_beat: assert property (take_w |=> !O_AUX.valid ##1 !O_AUX.valid ##[1:3] O_AUX.valid)
		else $error("first beat not in its slot");
	a_beat_gap: assert property (O_AUX.valid && !O_AUX.msg_end |-> ##[1:4] O_AUX.valid)
		else $error("gap inside a message");
	a_idle_clean: assert property (!O_AUX.valid |-> O_AUX.data == 4'h0 && !O_AUX.pkt_end && !O_AUX.msg_end)
		else $error("idle port not clean");
	a_end_marks: assert property (O_AUX.msg_end |-> O_AUX.valid && O_AUX.pkt_end && O_REQ_READY)
		else $error("message end without packet end or ready");
	a_busy_ready: assert property (O_AUX.valid && !O_AUX.msg_end |-> !O_REQ_READY)
		else $error("ready high in mid message");
	a_legal_code: assert property (O_AUX.valid && nbeat_reg == 8'h01 |-> {O_AUX.data[1:0], lo_reg} inside {6'h00, 6'h02, [6'h03:6'h06], 6'h08, 6'h09, [6'h0b:6'h0f], 6'h1b, 6'h21, [6'h38:6'h3b], 6'h3f})
		else $error("reserved transfer code sent");
	a_msg_bound: assert property (take_w |-> ##[4:130] O_AUX.msg_end)
		else $error("message did not end in time");
	a_watch_code: assert property (O_AUX.valid && nbeat_reg == 8'h00 && kind_reg == ntme_pkg::NTME_K_WATCH |-> O_AUX.data == 4'h8)
		else $error("watchpoint message code wrong");
endmodule

bind ntme_encoder ntme_encoder_asserts u_ntme_encoder_asserts (
	.I_CLK       (I_CLK),
	.I_SYS_RST   (I_SYS_RST),
	.I_REQ_VALID (I_REQ_VALID),
	.I_REQ       (I_REQ),
	.O_REQ_READY (O_REQ_READY),
	.O_AUX       (O_AUX)
);

// [verification/ntme_tb_top.sv]
// Self-checking bench: expected beats are queued by the driver and compared per beat.
// Assumes the probe model and the bound checker are compiled before this file.
`timescale 1ns/10ps
module nexus_trace_message_encoder_tb_top;
	logic                 I_CLK;
	logic                 I_SYS_RST;
	logic                 I_REQ_VALID;
	ntme_pkg::ntme_req_t  I_REQ;
	logic                 O_REQ_READY;
	ntme_pkg::ntme_beat_t O_AUX;
	logic                 rx_strobe;
	ntme_pkg::ntme_beat_t rx_beat;
	logic [15:0]          rx_msgs;
	ntme_pkg::ntme_beat_t exp_q[$];
	logic [3:0]           acc;
	int                   nb;
	int                   n_errors;
	int                   checks_done;
	int                   sent;
	int unsigned          seed;

	ntme_encoder u_ntme_encoder (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_REQ_VALID(I_REQ_VALID),
		.I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY), .O_AUX(O_AUX));
	ntme_probe u_ntme_probe (.i_clk(I_CLK), .i_rst(I_SYS_RST), .i_aux(O_AUX),
		.o_strobe(rx_strobe), .o_beat(rx_beat), .o_msgs(rx_msgs));

	initial begin
		I_CLK = 1'b0;
		forever #50 I_CLK = ~I_CLK;
	end

	task automatic check(logic [6:0] seen, logic [6:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic flush;
		exp_q.push_back('{1'b1, acc, 1'b0, 1'b0});
		acc = 4'h0;
		nb = 0;
	endtask

	// Appends one packet, least significant bit first.
	task automatic put(logic [31:0] v, int len, logic vr);
		int i;
		if (vr) begin
			len = 1;
			for (i = 0; i < 32; i++)
				if (v[i]) len = i + 1;
		end
		for (i = 0; i < len; i++) begin
			acc[nb] = v[i];
			nb++;
			if (nb == 4) flush();
		end
		if (vr && nb > 0) flush();
		if (vr) exp_q[$].pkt_end = 1'b1;
	endtask

	task automatic expect_msg(ntme_pkg::ntme_req_t r);
		logic s;
		s = r.sync_needed;
		acc = 4'h0;
		nb = 0;
		case (r.kind)
		ntme_pkg::NTME_K_DIRECT_TGT: begin
			put(6'h39, 6, 1'b0);
			put(r.instruction_count, 8, 1'b1);
			put(r.address, 32, 1'b1);
		end
		ntme_pkg::NTME_K_INDIRECT: begin
			put(s ? 6'h0c : 6'h04, 6, 1'b0);
			put(r.event_identifier, 2, 1'b0);
			put(r.instruction_count, 8, 1'b1);
			put(r.address, 32, 1'b1);
		end
		ntme_pkg::NTME_K_SYNC: begin
			put(6'h09, 6, 1'b0);
			put(r.instruction_count, 8, 1'b1);
			put(r.address, 32, 1'b1);
		end
		ntme_pkg::NTME_K_RES_FULL: begin
			put(6'h1b, 6, 1'b0);
			put(r.code4, 4, 1'b0);
			put(r.resource_data, 8, 1'b1);
		end
		ntme_pkg::NTME_K_CORREL: begin
			put(6'h21, 6, 1'b0);
			put(r.code4, 4, 1'b0);
			put(r.instruction_count, 8, 1'b1);
		end
		ntme_pkg::NTME_K_WRITE, ntme_pkg::NTME_K_READ: begin
			if (r.kind == ntme_pkg::NTME_K_WRITE)
				put(s ? 6'h0d : 6'h05, 6, 1'b0);
			else
				put(s ? 6'h0e : 6'h06, 6, 1'b0);
			put(r.two_bit_field, 2, 1'b0);
			put(r.address, 32, 1'b1);
			put(r.data, 32, 1'b1);
		end
		ntme_pkg::NTME_K_RMW: begin
			put(s ? 6'h3b : 6'h3a, 6, 1'b0);
			put(r.two_bit_field, 2, 1'b0);
			put(r.bit_number, 5, 1'b0);
			put(r.address, 32, 1'b1);
		end
		ntme_pkg::NTME_K_WATCH: begin
			put(6'h38, 6, 1'b0);
			put(r.two_bit_field, 2, 1'b0);
		end
		default: begin
			put(s ? 6'h0b : 6'h03, 6, 1'b0);
			put(r.instruction_count, 8, 1'b1);
			if (s) put(r.address, 32, 1'b1);
		end
		endcase
		if (nb > 0) flush();
		exp_q[$].pkt_end = 1'b1;
		exp_q[$].msg_end = 1'b1;
	endtask

	function automatic ntme_pkg::ntme_req_t rnd(ntme_pkg::ntme_kind_t k, logic s);
		logic [127:0] w;
		ntme_pkg::ntme_req_t r;
		w = {$urandom, $urandom, $urandom, $urandom};
		r = w[$bits(r)-1:0];
		r.kind = k;
		r.sync_needed = s;
		r.instruction_count = r.instruction_count >> ($urandom % 8);
		r.address = r.address >> ($urandom % 32);
		r.data = r.data >> ($urandom % 32);
		return r;
	endfunction

	// Called just after an edge; returns just after the accept edge with the request held.
	task automatic send(ntme_pkg::ntme_req_t r);
		int k;
		expect_msg(r);
		sent++;
		I_REQ = r;
		I_REQ_VALID = 1'b1;
		for (k = 0; k < 400; k++) begin
			@(posedge I_CLK);
			if (O_REQ_READY === 1'b1) break;
		end
		if (k == 400) begin
			n_errors++;
			end_of_test();
		end
		#1;
	endtask

	always @(negedge I_CLK) begin
		if (rx_strobe === 1'b1) begin
			if (exp_q.size() == 0)
				check(rx_beat, 'x);
			else
				check(rx_beat, exp_q.pop_front());
		end
	end

	initial begin
		int k;
		int s;
		logic [31:0] bnd_v [5];
		ntme_pkg::ntme_req_t r;
		bnd_v = '{32'h0, 32'h1, 32'hf, 32'h10, 32'hffffffff};
		seed = $urandom(32'h1ee6);
		I_SYS_RST = 1'b1;
		I_REQ_VALID = 1'b0;
		I_REQ = '0;
		repeat (4) @(posedge I_CLK);
		#1;
		I_SYS_RST = 1'b0;
		repeat (2) @(posedge I_CLK);
		#1;
		for (k = 0; k < 10; k++)
			for (s = 0; s < 2; s++)
				send(rnd(ntme_pkg::ntme_kind_t'(k[3:0]), s[0]));
		foreach (bnd_v[i]) begin
			r = rnd(ntme_pkg::NTME_K_DIRECT_TGT, 1'b0);
			r.instruction_count = bnd_v[i][7:0];
			r.address = bnd_v[i];
			send(r);
			r.kind = ntme_pkg::NTME_K_WRITE;
			r.sync_needed = 1'b1;
			r.data = bnd_v[i];
			send(r);
			I_REQ_VALID = 1'b0;
			repeat (1 + ($urandom % 6)) @(posedge I_CLK);
			#1;
		end
		send(rnd(ntme_pkg::ntme_kind_t'(4'hf), 1'b0));
		send(rnd(ntme_pkg::NTME_K_READ, 1'b1));
		I_REQ_VALID = 1'b0;
		repeat (12) @(posedge I_CLK);
		#1;
		I_SYS_RST = 1'b1;
		repeat (2) @(posedge I_CLK);
		#1;
		exp_q.delete();
		sent = 0;
		I_SYS_RST = 1'b0;
		repeat (2) @(posedge I_CLK);
		#1;
		send(rnd(ntme_pkg::NTME_K_WATCH, 1'b0));
		send(rnd(ntme_pkg::NTME_K_CORREL, 1'b1));
		I_REQ_VALID = 1'b0;
		for (k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge I_CLK);
		repeat (2) @(posedge I_CLK);
		if (exp_q.size() != 0) n_errors++;
		check(rx_msgs[6:0], 7'(sent));
		check({6'h00, O_REQ_READY}, 7'h01);
		end_of_test();
	end
endmodule
